/* File: rtl/adc_host.sv */
`timescale 1ns/10ps
// Operation
// - Host holds select low during access
// - Short read pulse within 80..400 ns
// - Read qualified by select starts and fetches
// - Host drives three channel address bits
// - Read falling edge starts, latches address
module adc_host import adc_host_pkg::*; #(
  // Conversion allowance in cycles; a fast model may use a shorter one
  parameter int unsigned CONV_CYCLES = CONV_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  // User request side
  input wire logic start,
  input wire read_mode_e mode,
  input wire logic [CHAN_W-1:0] chan,
  // Status and result
  output logic busy,
  output logic result_valid,
  output adc_result_s result,
  output logic timeout,
  // Converter pins
  output adc_drive_s drive,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic done_n_in,
  input wire logic ready_n_in
);
  // One state per phase of an access
  typedef enum logic [2:0] {ST_IDLE, ST_HOLD, ST_PULSE, ST_WAIT, ST_FETCH, ST_GAP} state_e;

  // Sequencer registers
  state_e state_reg; // Sequencer state
  logic [CNT_W-1:0] cnt_reg; // Shared cycle counter
  read_mode_e mode_reg; // Mode of the running access
  // Pin levels after the synchroniser
  logic [DATA_W-1:0] data_sync; // Synchronised data bus
  logic done_n_sync; // Synchronised done line
  logic ready_n_sync; // Synchronised ready line, released at conversion end
  logic conv_done; // Both completion lines agree
  logic [CNT_W-1:0] wait_limit; // Wait allowance for the running mode
  logic wait_over; // Allowance used up

  // Converter pins are asynchronous to core_clk
  // Idle levels at reset: bus low, done and ready high (inactive)
  pin_sync #(.W(DATA_W + 2), .INIT({{DATA_W{1'b0}}, 2'b11})) u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .din({data_in, done_n_in, ready_n_in}),
    .dout({data_sync, done_n_sync, ready_n_sync})
  );

  // Completion as seen through the synchronisers. Done falling and ready
  // being released come from one event on the part and pass the same
  // chain, so they agree on the same edge; asking for both keeps a lone
  // glitch on one line from cutting the wait short.
  always_comb begin
    conv_done = !done_n_sync && ready_n_sync;
    // Held mode counts from the read fall, so its allowance also covers
    // the access time after done
    if (mode_reg == MODE_PULSE) begin
      wait_limit = CNT_W'(CONV_CYCLES);
    end else begin
      // Held mode counts from the read fall, so the access time is added to its allowance
      wait_limit = CNT_W'(CONV_CYCLES + ACC_CYC);
    end
    wait_over = (cnt_reg >= wait_limit);
  end

  // Sequencer: select, read, wait for done, fetch, rest
  // Only one access runs at a time; a request while busy is dropped
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      // Counter and mode cleared with the state
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      mode_reg <= MODE_HELD;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // Counter parked at zero so every phase counts from a clean start
          cnt_reg <= '0;
          if (start) begin
            // Mode kept for the whole access; the user may change it at once
            mode_reg <= mode;
            // Path by mode: one long read, or a pulse then a fetch read
            state_reg <= (mode == MODE_PULSE) ? ST_PULSE : ST_HOLD;
          end
        end
        // Held read: read stays low until done falls, then data is valid
        ST_HOLD: begin
          cnt_reg <= cnt_reg + 1'b1;
          // A missing done line still ends in a fetch, flagged as a timeout
          if (conv_done || wait_over) begin
            state_reg <= ST_FETCH;
            cnt_reg <= '0;
          end
        end
        // Short pulse: fixed width inside the legal window
        ST_PULSE: begin
          cnt_reg <= cnt_reg + 1'b1;
          // Read is low for exactly the minimum count, well under the maximum
          if (cnt_reg == CNT_W'(RD_PULSE_MIN_CYC)) begin
            state_reg <= ST_WAIT;
            cnt_reg <= '0;
          end
        end
        // Wait for done, then read the result with a second pulse
        ST_WAIT: begin
          cnt_reg <= cnt_reg + 1'b1;
          // Select stays low, so ready keeps tracking the running conversion
          if (conv_done || wait_over) begin
            state_reg <= ST_FETCH;
            cnt_reg <= '0;
          end
        end
        // Read held low long enough for access time, then sample
        ST_FETCH: begin
          cnt_reg <= cnt_reg + 1'b1;
          // Three cycles past the access time, one per sync stage; the filter flop's fourth cycle is not counted
          if (cnt_reg == CNT_W'(ACC_CYC + 3)) begin
            state_reg <= ST_GAP;
            cnt_reg <= '0;
          end
        end
        // Recovery between conversions with select high
        ST_GAP: begin
          cnt_reg <= cnt_reg + 1'b1;
          // Runs one past the count so the rest is never short
          if (cnt_reg == CNT_W'(GAP_CYC)) begin
            state_reg <= ST_IDLE;
          end
        end
        // Unused codes fall back to idle
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Pin drive: select low around every read, address held through state
  // Every pin comes from a flop, so no glitch reaches the part
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      // Both strobes idle high; address lines parked low
      drive <= '{cs_n: 1'b1, rd_n: 1'b1, default: 1'b0};
    end else begin
      case (state_reg)
        // Idle: read high, select follows the request
        ST_IDLE: begin
          drive.rd_n <= 1'b1;
          drive.cs_n <= !start;
          if (start) begin
            // Address set up with select, ahead of read fall
            {drive.chan_sel_bit_high, drive.chan_sel_bit_mid, drive.chan_sel_bit_low} <= chan;
          end
        end
        // Held read: read falls one cycle after select and stays low
        ST_HOLD: drive.rd_n <= 1'b0;
        // Short pulse: read rises once the width count is reached
        ST_PULSE: drive.rd_n <= (cnt_reg == CNT_W'(RD_PULSE_MIN_CYC));
        // Between pulse and fetch read is high and select stays low
        ST_WAIT: drive.rd_n <= 1'b1; // Address held long past its hold time
        // Fetch: read and select rise together as the sample is taken
        ST_FETCH: begin
          // Address lines untouched, so their hold time is met with room
          drive.rd_n <= (cnt_reg == CNT_W'(ACC_CYC + 3));
          drive.cs_n <= (cnt_reg == CNT_W'(ACC_CYC + 3));
        end
        // Gap and unused codes: both strobes released
        default: begin
          drive.rd_n <= 1'b1;
          drive.cs_n <= 1'b1;
        end
      endcase
    end
  end

  // Result capture at access time plus three cycles, one short of the four-cycle synchroniser latency
  // Data bits cross one by one; at worst-case access time they are still in the synchroniser when sampled
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      // Result and flags cleared
      result <= '0;
      result_valid <= 1'b0;
      timeout <= 1'b0;
    end else begin
      // Valid is a one-cycle strobe
      result_valid <= 1'b0;
      if (state_reg == ST_FETCH && cnt_reg == CNT_W'(ACC_CYC + 3)) begin
        result.data <= data_sync;
        // Channel reported is the one on the pins, not the live request
        result.chan <= {drive.chan_sel_bit_high, drive.chan_sel_bit_mid, drive.chan_sel_bit_low};
        result_valid <= 1'b1;
      end
      // Done never seen: flag it, the sequence still completes
      if ((state_reg == ST_WAIT || state_reg == ST_HOLD) && wait_over && !conv_done) begin
        timeout <= 1'b1;
      end else if (start && state_reg == ST_IDLE) begin
        // A new request clears the flag of the previous one
        timeout <= 1'b0;
      end
    end
  end

  // Busy flag from registered state
  // Raised with the request itself, so a second start is never taken
  // Falls on the last gap cycle, the same edge that returns to idle
  // Comes straight from a flop like every other output
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
    end else begin
      busy <= !(state_reg == ST_IDLE && !start) && !(state_reg == ST_GAP &&
              cnt_reg == CNT_W'(GAP_CYC));
    end
  end
endmodule // adc_host

/* File: rtl/adc_host_pkg.sv */
package adc_host_pkg;
  // Clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 10000;
  // Mode 0 conversion time, worst case across military grade, in ns
  localparam int unsigned CONV_MAX_NS = 2800;
  localparam int unsigned CONV_CYC = (CONV_MAX_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Mode 1 read pulse window in ns: least of the wide grades, longest of the narrowest
  localparam int unsigned RD_PULSE_MIN_NS = 80;
  localparam int unsigned RD_PULSE_MAX_NS = 400;
  localparam int unsigned RD_PULSE_MIN_CYC =
    (RD_PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RD_PULSE_MAX_CYC = (RD_PULSE_MAX_NS * 1000) / CLK_PERIOD_PS;
  // Access time after read falls, worst case, in ns
  localparam int unsigned ACC_MAX_NS = 120;
  localparam int unsigned ACC_CYC = (ACC_MAX_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Address hold after read, worst case, in ns
  localparam int unsigned ADDR_HOLD_NS = 40;
  localparam int unsigned ADDR_HOLD_CYC =
    (ADDR_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Delay between conversions, worst case, in ns
  localparam int unsigned GAP_NS = 600;
  localparam int unsigned GAP_CYC = (GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Counter width covering the longest count
  localparam int unsigned CNT_W = 10;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CHAN_W = 3;

  // Read modes: held read (mode 0) and short pulse (mode 1)
  typedef enum logic {MODE_HELD, MODE_PULSE} read_mode_e;

  // Pins driven toward the converter
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic chan_sel_bit_high;
    logic chan_sel_bit_mid;
    logic chan_sel_bit_low;
  } adc_drive_s;

  // Result returned to the user
  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic [DATA_W-1:0] data;
  } adc_result_s;
endpackage

/* File: rtl/pin_sync.sv */
`timescale 1ns/10ps
// Three-stage synchroniser; a change counts once stages two and three agree
module pin_sync import adc_host_pkg::*; #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_reg; // Metastability catcher, read only by s2
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // Shift chain
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Filtered level per bit: update only on agreement
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic q_reg;
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        q_reg <= INIT[i];
      end else if (s2_reg[i] == s3_reg[i]) begin
        q_reg <= s3_reg[i];
      end
    end
    assign dout[i] = q_reg;
  end
endmodule // pin_sync

/* File: tb/adc_host_checker.sv */
`timescale 1ns/10ps
// Pin sequencing watcher for the converter host
module adc_host_checker import adc_host_pkg::*; #(
  parameter int unsigned CONV_CYCLES = CONV_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic start,
  input wire read_mode_e mode,
  input wire logic [CHAN_W-1:0] chan,
  input wire logic busy,
  input wire logic result_valid,
  input wire adc_drive_s drive,
  input wire logic done_n_in
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Address as the converter sees it
  logic [CHAN_W-1:0] addr;
  assign addr = {drive.chan_sel_bit_high, drive.chan_sel_bit_mid, drive.chan_sel_bit_low};
  a_read_needs_select: assert property (!drive.rd_n |-> !drive.cs_n)
    else $error("read low while deselected");
  a_start_opens_read: assert property (start && !busy |=> !drive.cs_n ##1 !drive.rd_n)
    else $error("start did not open a read");
  a_addr_from_start: assert property (start && !busy |=> addr == $past(chan))
    else $error("address differs from request");
  // Hold time after the read edge spans four cycles
  a_addr_hold: assert property ($fell(drive.rd_n) |=> $stable(addr)[*4])
    else $error("address moved during hold");
  a_pulse_width: assert property ($fell(drive.rd_n) && mode == MODE_PULSE && done_n_in
    |-> !drive.rd_n[*8] ##1 drive.rd_n)
    else $error("short read pulse wrong width");
  a_fetch_ends_read: assert property (result_valid |-> drive.rd_n && !$past(drive.rd_n))
    else $error("result without fetch read");
endmodule // adc_host_checker
bind adc_host adc_host_checker #(.CONV_CYCLES(CONV_CYCLES)) adc_host_checker_inst (
  .core_clk(core_clk), .rstn(rstn), .start(start), .mode(mode), .chan(chan),
  .busy(busy), .result_valid(result_valid), .drive(drive), .done_n_in(done_n_in));

/* File: tb/adc_dev_model.sv */
`timescale 1ns/10ps
// Clockless converter, timed only from its pins
module adc_dev_model import adc_host_pkg::*; (
  input wire adc_drive_s drive,
  input wire logic stall,
  output logic [DATA_W-1:0] data_in,
  output logic done_n_in,
  output logic ready_n_in
);
  logic [CHAN_W-1:0] ch; // Channel latched at start
  logic [DATA_W-1:0] res = 8'h00; // Output latches
  logic sel; // Selected read
  assign sel = !drive.cs_n && !drive.rd_n;
  initial done_n_in = 1'b1;
  // A read with no result pending starts a conversion
  always @(posedge sel) begin
    if (done_n_in) begin
      ch = {drive.chan_sel_bit_high, drive.chan_sel_bit_mid, drive.chan_sel_bit_low};
      #1000;
      res[7:4] = 4'h9 ^ {1'b0, ch};
      #600;
      // Stall models a part that never finishes
      if (!stall) begin
        res[3:0] = 4'h6 ^ {1'b0, ch};
        done_n_in = 1'b0;
      end
    end
  end
  // End of the fetch read re-arms the done line
  always @(negedge sel) done_n_in = 1'b1;
  // Released bus shows a wrong value rather than a stale one
  assign data_in = sel ? res : ~res;
  // Board pull-up gives the high level
  assign ready_n_in = drive.cs_n || !done_n_in;
endmodule // adc_dev_model

/* File: tb/adc_host_tb.sv */
`timescale 1ns/10ps
// Whole conversions through host and converter model
module adc_host_tb import adc_host_pkg::*;;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic start = 1'b0;
  read_mode_e mode = MODE_HELD;
  logic [CHAN_W-1:0] chan = '0;
  logic stall = 1'b0;
  logic busy, result_valid, timeout, done_n_in, ready_n_in;
  adc_result_s result;
  adc_drive_s drive;
  logic [DATA_W-1:0] data_in;
  int fails = 0;
  int check_count = 0;
  adc_host adc_host_inst (.core_clk(core_clk), .rstn(rstn), .start(start), .mode(mode),
    .chan(chan), .busy(busy), .result_valid(result_valid), .result(result),
    .timeout(timeout), .drive(drive), .data_in(data_in), .done_n_in(done_n_in),
    .ready_n_in(ready_n_in));
  adc_dev_model adc_dev_model_inst (.drive(drive), .stall(stall), .data_in(data_in),
    .done_n_in(done_n_in), .ready_n_in(ready_n_in));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // One conversion; poke sends a second start while busy, which must be ignored
  task automatic convert(input read_mode_e m, input logic [2:0] c, input bit poke,
    input logic to);
    adc_result_s got;
    int seen;
    int n;
    seen = 0;
    got = '0;
    mode = m;
    chan = c;
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    chan = ~c;
    for (n = 0; busy !== 1'b0; n++) begin
      if (n > 800) begin
        fails++;
        tally_and_finish;
      end
      if (result_valid === 1'b1) begin
        got = result;
        seen++;
      end
      if (poke) start = (n == 20);
      @(negedge core_clk);
    end
    check(16'(seen), 16'h0001);
    check(16'(got), {5'h00, c, 4'h9 ^ {1'b0, c}, 4'h6 ^ {1'b0, c}});
    check(16'(timeout), 16'(to));
  endtask
  task automatic scen_reset;
    check(16'({drive, busy, result_valid, timeout}), 16'h00C0);
  endtask
  task automatic scen_channels;
    for (int c = 0; c < 8; c++) begin
      convert(MODE_HELD, 3'(c), 1'b0, 1'b0);
      convert(MODE_PULSE, 3'(c), 1'b0, 1'b0);
    end
  endtask
  task automatic scen_refused;
    convert(MODE_HELD, 3'h5, 1'b1, 1'b0);
  endtask
  // Missing done line; the next start must clear the flag
  task automatic scen_timeout;
    convert(MODE_HELD, 3'h2, 1'b0, 1'b0);
    stall = 1'b1;
    convert(MODE_HELD, 3'h2, 1'b0, 1'b1);
    stall = 1'b0;
    convert(MODE_PULSE, 3'h2, 1'b0, 1'b0);
  endtask
  initial begin
    repeat (12) @(negedge core_clk);
    rstn = 1'b1;
    scen_reset;
    scen_channels;
    scen_refused;
    scen_timeout;
    tally_and_finish;
  end
endmodule // adc_host_tb
